// >>> hw/mirs_reset_seq.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - A valid request resets the interface and then runs a full calibration.
// - The request is sampled asynchronously; only its pulse width matters.
// - Reset-done rises only when finished, out of reset, and ready for requests.
// - Reset-done stays low for the whole time the interface is in reset.
// - The lock output follows whether the interface PLL has locked.
// - Up to four extra core clocks, each present only when configured.
// - Extra core clocks are unrelated to the interface core clock domains.
// - User reset asserts asynchronously and releases synchronously to the user clock.
// - After calibration a pass or a fail indication goes high.
module mirs_reset_seq #(
  parameter int CAL_TIMEOUT = mirs_pkg::CAL_TIMEOUT_CYC
) (
  // Clock, reset and clock enable.
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               ce,
  // Register bus.
  input  wire mirs_pkg::mirs_bus_s                bus,
  output logic      [mirs_pkg::DATA_W-1:0]        rdata,
  // Reset request and status to user logic.
  input  wire logic                               resetReqPin,
  output logic                                    resetDone,
  output logic                                    usrResetN,
  // PLL lock from the analog PLL and its reported state.
  input  wire logic                               pllLockPin,
  output logic                                    pllLocked,
  // Extra core clocks.
  output logic      [mirs_pkg::N_XCLK-1:0]        xclk,
  // Calibration engine handshake.
  output logic                                    calStart,
  input  wire logic                               phyCalDone,
  input  wire logic                               phyCalPass,
  output logic                                    calSuccess,
  output logic                                    calFail,
  // Interrupt.
  output logic                                    irq
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic reqSync;
  logic lockSync;
  logic reqDly_r;
  logic reqDlyNxt;
  logic reqEdge;

  // Both pins come from outside the core domain. A request of two core
  // clocks is long enough to be caught by the synchroniser.
  mirs_sync2 #(.W(2)) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({resetReqPin, pllLockPin}),
    .q   ({reqSync, lockSync})
  );

  // Rising edge of the synchronised request; a held-high line fires once.
  always_comb begin
    reqDlyNxt = ce ? reqSync : reqDly_r;
    reqEdge   = reqSync & ~reqDly_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reqDly_r <= 1'b0;
    end else begin
      reqDly_r <= reqDlyNxt;
    end
  end

  // ----------------------------------------------------------------
  // Reset and calibration sequencer
  // ----------------------------------------------------------------
  mirs_pkg::mirs_state_e            state_r;
  mirs_pkg::mirs_state_e            stateNxt;
  logic [mirs_pkg::CNT_W-1:0]       cnt_r;
  logic [mirs_pkg::CNT_W-1:0]       cntNxt;
  mirs_pkg::mirs_stat_s             stat_r;
  mirs_pkg::mirs_stat_s             statNxt;
  logic                             calStartNxt;
  logic [1:0]                       usrRst_r;
  logic [1:0]                       usrRstNxt;
  logic                             softReq;
  logic                             accept;
  logic                             inReset;
  logic [mirs_pkg::IRQ_W-1:0]       evt;

  // Requests are taken only when ready; a request raised during a reset is
  // dropped, since the sequence it would restart is already running.
  assign accept  = (state_r == mirs_pkg::ST_READY) && (reqEdge || softReq);
  assign inReset = (state_r != mirs_pkg::ST_READY);

  // Next state, hold/timeout counter and status flags.
  always_comb begin
    stateNxt    = state_r;
    cntNxt      = cnt_r;
    statNxt     = stat_r;
    calStartNxt = 1'b0;
    evt         = '0;
    if (ce) begin
      statNxt.pllLocked = lockSync;
      unique case (state_r)
        mirs_pkg::ST_WAIT_LOCK: begin
          cntNxt = '0;
          if (lockSync) begin
            stateNxt = mirs_pkg::ST_HOLD;
          end
        end
        mirs_pkg::ST_HOLD: begin
          if (cnt_r == mirs_pkg::CNT_W'(mirs_pkg::RST_HOLD_CYC - 1)) begin
            cntNxt      = '0;
            stateNxt    = mirs_pkg::ST_CAL;
            calStartNxt = 1'b1;
          end else begin
            cntNxt = cnt_r + 1'b1;
          end
        end
        mirs_pkg::ST_CAL: begin
          cntNxt = cnt_r + 1'b1;
          if (phyCalDone) begin
            stateNxt        = mirs_pkg::ST_READY;
            statNxt.calPass = phyCalPass;
            statNxt.calFail = ~phyCalPass;
          end else if (cnt_r == mirs_pkg::CNT_W'(CAL_TIMEOUT - 1)) begin
            // A silent calibration engine must not hang the sequence.
            stateNxt        = mirs_pkg::ST_READY;
            statNxt.calFail = 1'b1;
          end
          if (stateNxt == mirs_pkg::ST_READY) begin
            evt[mirs_pkg::IRQ_DONE]    = 1'b1;
            evt[mirs_pkg::IRQ_CALFAIL] = statNxt.calFail;
          end
        end
        mirs_pkg::ST_READY: begin
          if (accept) begin
            stateNxt                  = mirs_pkg::ST_HOLD;
            cntNxt                    = '0;
            statNxt.calPass           = 1'b0;
            statNxt.calFail           = 1'b0;
            evt[mirs_pkg::IRQ_REQACC] = 1'b1;
          end
        end
      endcase
      // Losing lock overrides state, calStart, flags and the done event, and restarts from the top.
      if (!lockSync && state_r != mirs_pkg::ST_WAIT_LOCK) begin
        stateNxt                    = mirs_pkg::ST_WAIT_LOCK;
        calStartNxt                 = 1'b0;
        statNxt.calPass             = 1'b0;
        statNxt.calFail             = 1'b0;
        evt[mirs_pkg::IRQ_LOCKLOST] = 1'b1;
        evt[mirs_pkg::IRQ_DONE]     = 1'b0;
      end
      statNxt.resetDone = (stateNxt == mirs_pkg::ST_READY);
      // User reset goes low at once and climbs out through two flops.
      usrRstNxt = (stateNxt != mirs_pkg::ST_READY) ? 2'h0 : {usrRst_r[0], 1'b1};
    end else begin
      usrRstNxt = usrRst_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= mirs_pkg::ST_WAIT_LOCK;
      cnt_r    <= '0;
      stat_r   <= '0;
      calStart <= 1'b0;
      usrRst_r <= 2'h0;
    end else begin
      state_r  <= stateNxt;
      cnt_r    <= cntNxt;
      stat_r   <= statNxt;
      calStart <= calStartNxt;
      usrRst_r <= usrRstNxt;
    end
  end

  assign resetDone  = stat_r.resetDone;
  assign pllLocked  = stat_r.pllLocked;
  assign calSuccess = stat_r.calPass;
  assign calFail    = stat_r.calFail;
  assign usrResetN  = usrRst_r[1];

  // ----------------------------------------------------------------
  // Register file and interrupt
  // ----------------------------------------------------------------
  logic [mirs_pkg::N_XCLK-1:0] xclkEn_r;
  logic [mirs_pkg::N_XCLK-1:0] xclkEnNxt;
  logic [mirs_pkg::IRQ_W-1:0]  irqStat_r;
  logic [mirs_pkg::IRQ_W-1:0]  irqStatNxt;
  logic [mirs_pkg::IRQ_W-1:0]  irqMask_r;
  logic [mirs_pkg::IRQ_W-1:0]  irqMaskNxt;
  logic [mirs_pkg::DATA_W-1:0] rdataNxt;
  logic                        irqNxt;

  assign softReq = ce && bus.wr && (bus.addr == mirs_pkg::REG_CTRL)
                   && bus.wdata[mirs_pkg::CTRL_SOFT_REQ];

  // Writes, write-one-to-clear status and read mux. A new event beats a
  // clear in the same cycle so no event is lost.
  always_comb begin
    xclkEnNxt  = xclkEn_r;
    irqStatNxt = irqStat_r;
    irqMaskNxt = irqMask_r;
    rdataNxt   = rdata;
    irqNxt     = irq;
    if (ce) begin
      rdataNxt = '0;
      if (bus.wr) begin
        unique case (bus.addr)
          mirs_pkg::REG_CTRL:
            xclkEnNxt = bus.wdata[mirs_pkg::CTRL_XCLK_LSB +: mirs_pkg::N_XCLK];
          mirs_pkg::REG_IRQ_STAT: irqStatNxt = irqStat_r & ~bus.wdata[mirs_pkg::IRQ_W-1:0];
          mirs_pkg::REG_IRQ_MASK: irqMaskNxt = bus.wdata[mirs_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
      irqStatNxt = irqStatNxt | evt;
      if (bus.rd) begin
        unique case (bus.addr)
          mirs_pkg::REG_CTRL:
            rdataNxt[mirs_pkg::CTRL_XCLK_LSB +: mirs_pkg::N_XCLK] = xclkEn_r;
          mirs_pkg::REG_STATUS: begin
            rdataNxt[mirs_pkg::STAT_FLAGS_LSB +: 4] = stat_r;
            rdataNxt[mirs_pkg::STAT_STATE_LSB +: 2] = 2'(state_r);
          end
          mirs_pkg::REG_IRQ_STAT: rdataNxt[mirs_pkg::IRQ_W-1:0] = irqStat_r;
          mirs_pkg::REG_IRQ_MASK: rdataNxt[mirs_pkg::IRQ_W-1:0] = irqMask_r;
          default: ;
        endcase
      end
      irqNxt = |(irqStatNxt & irqMaskNxt);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xclkEn_r  <= mirs_pkg::XCLK_EN_RST;
      irqStat_r <= '0;
      irqMask_r <= mirs_pkg::IRQ_MASK_RST;
      rdata     <= '0;
      irq       <= 1'b0;
    end else begin
      xclkEn_r  <= xclkEnNxt;
      irqStat_r <= irqStatNxt;
      irqMask_r <= irqMaskNxt;
      rdata     <= rdataNxt;
      irq       <= irqNxt;
    end
  end

  // ----------------------------------------------------------------
  // Extra core clocks
  // ----------------------------------------------------------------
  // Each divider has its own ratio, so its edges bear no fixed phase to the
  // user clock; users must synchronise anything that crosses.
  for (genvar i = 0; i < mirs_pkg::N_XCLK; i++) begin : g_xclk
    mirs_clk_div #(.HALF(mirs_pkg::XCLK_HALF[i])) u_div (
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .en     (xclkEn_r[i]),
      .clkOut (xclk[i])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int unsigned calWait;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      calWait <= 0;
    end else if (ce) begin
      calWait <= (state_r == mirs_pkg::ST_CAL) ? calWait + 1 : 0;
    end
  end

  chk_done_low_reset: assert property (@(posedge clk) disable iff (rst)
    (inReset && ce && !(state_r == mirs_pkg::ST_CAL && (phyCalDone
      || cnt_r == mirs_pkg::CNT_W'(CAL_TIMEOUT - 1)))) |=> !resetDone)
    else $error("reset-done high while in reset");

  chk_req_starts_seq: assert property (@(posedge clk) disable iff (rst)
    (ce && state_r == mirs_pkg::ST_READY && reqEdge && lockSync)
      |=> state_r == mirs_pkg::ST_HOLD && !resetDone)
    else $error("accepted request did not start reset");

  chk_done_means_ready: assert property (@(posedge clk) disable iff (rst)
    resetDone |-> state_r == mirs_pkg::ST_READY && pllLocked && usrRst_r[0])
    else $error("reset-done high outside ready state");

  chk_hold_length: assert property (@(posedge clk) disable iff (rst)
    (state_r == mirs_pkg::ST_HOLD && stateNxt == mirs_pkg::ST_CAL)
      |-> cnt_r == mirs_pkg::CNT_W'(mirs_pkg::RST_HOLD_CYC - 1) ##1 calStart)
    else $error("reset hold length wrong");

  chk_lock_loss: assert property (@(posedge clk) disable iff (rst)
    (ce && !lockSync) |=> !pllLocked && !resetDone)
    else $error("lock loss not reported");

  chk_pass_fail_excl: assert property (@(posedge clk) disable iff (rst)
    !(calSuccess && calFail))
    else $error("pass and fail both high");

  chk_usr_rst_release: assert property (@(posedge clk) disable iff (rst)
    $rose(usrResetN) |-> $past(resetDone) && resetDone)
    else $error("user reset released early");

  chk_cal_timeout: assert property (@(posedge clk) disable iff (rst)
    (ce && lockSync && state_r == mirs_pkg::ST_CAL && !phyCalDone
      && calWait == CAL_TIMEOUT - 1) |=> calFail && resetDone)
    else $error("calibration timeout not flagged");

  chk_xclk_off: assert property (@(posedge clk) disable iff (rst)
    (!xclkEn_r[0] && !xclkEn_r[1]) [*2] |-> xclk[1:0] == 2'h0)
    else $error("disabled extra clock toggling");

  cov_req_taken: cover property (@(posedge clk) disable iff (rst)
    accept ##[1:40] state_r == mirs_pkg::ST_CAL);
  cov_cal_pass: cover property (@(posedge clk) disable iff (rst) $rose(calSuccess));
  cov_cal_fail: cover property (@(posedge clk) disable iff (rst) $rose(calFail));
  cov_lock_lost: cover property (@(posedge clk) disable iff (rst) evt[mirs_pkg::IRQ_LOCKLOST]);

endmodule

// >>> hw/mirs_pkg.sv
package mirs_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry and map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK = 8'h0C;

  // Control register fields and reset value.
  localparam int          CTRL_SOFT_REQ = 0;
  localparam int          CTRL_XCLK_LSB = 4;
  localparam int          N_XCLK        = 4;
  localparam logic [3:0]  XCLK_EN_RST   = 4'h0;

  // Status register fields.
  localparam int          STAT_FLAGS_LSB = 0;
  localparam int          STAT_STATE_LSB = 4;

  // Interrupt bit positions, shared by status and mask registers.
  localparam int          IRQ_W        = 4;
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_CALFAIL  = 1;
  localparam int          IRQ_LOCKLOST = 2;
  localparam int          IRQ_REQACC   = 3;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int REQ_MIN_CYC     = 2;
  localparam int RST_HOLD_NS     = 100;
  localparam int RST_HOLD_CYC    = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAL_TIMEOUT_US  = 100;
  localparam int CAL_TIMEOUT_CYC = (CAL_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int CNT_W           = 16;

  // Half periods of the extra core clocks, in core clock cycles.
  localparam int XCLK_HALF [N_XCLK] = '{1, 2, 3, 4};
  localparam int XCLK_CNT_W         = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum {ST_WAIT_LOCK, ST_HOLD, ST_CAL, ST_READY} mirs_state_e;

  typedef struct packed {
    logic calFail;
    logic calPass;
    logic pllLocked;
    logic resetDone;
  } mirs_stat_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mirs_bus_s;

endpackage

// >>> hw/mirs_sync2.sv
`timescale 1ns/10ps
module mirs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] metaNxt;
  logic [W-1:0] qNxt;

  // Two flops in a row; only the second flop reads the first.
  always_comb begin
    metaNxt = ce ? d : meta_r;
    qNxt    = ce ? meta_r : q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= metaNxt;
      q      <= qNxt;
    end
  end

endmodule

// >>> hw/mirs_clk_div.sv
`timescale 1ns/10ps
module mirs_clk_div #(
  parameter int HALF = 1
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Enable and divided clock.
  input  wire logic en,
  output logic      clkOut
);

  logic [mirs_pkg::XCLK_CNT_W-1:0] cnt_r;
  logic [mirs_pkg::XCLK_CNT_W-1:0] cntNxt;
  logic                            clkNxt;

  // A disabled output is parked low so that it looks absent to its user.
  always_comb begin
    cntNxt = cnt_r;
    clkNxt = clkOut;
    if (ce) begin
      if (!en) begin
        cntNxt = '0;
        clkNxt = 1'b0;
      end else if (cnt_r == mirs_pkg::XCLK_CNT_W'(HALF - 1)) begin
        cntNxt = '0;
        clkNxt = ~clkOut;
      end else begin
        cntNxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      clkOut <= 1'b0;
    end else begin
      cnt_r  <= cntNxt;
      clkOut <= clkNxt;
    end
  end

endmodule

// >>> sim/mirs_user_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// User logic partner and stand-in calibration engine.
// ----------------------------------------------------------------
module mirs_user_model (
  // Clock.
  input  wire logic clk,
  // Status from the sequencer.
  input  wire logic resetDone,
  input  wire logic calStart,
  // Request pin and calibration answers.
  output logic      resetReqPin,
  output logic      phyCalDone,
  output logic      phyCalPass
);
  int calMode   = 0;  // 0 pass, 1 fail, 2 never answers.
  int calLat    = 4;
  int calStarts = 0;

  // Idle pass level is the inverse of the result last given, so a sequencer that
  // reads it without the done strobe gets the wrong answer.
  initial begin
    resetReqPin = 1'b0;
    phyCalDone  = 1'b0;
    phyCalPass  = 1'b0;
  end

  // Request pulse, moved off the clock edge since the pin is asynchronous.
  task automatic pulseReq(input int width);
    while (resetDone !== 1'b1) @(posedge clk);
    @(posedge clk);
    #1.3 resetReqPin = 1'b1;
    repeat (width) @(posedge clk);
    #1.3 resetReqPin = 1'b0;
  endtask

  // Count calibration starts.
  always @(posedge clk) begin
    if (calStart === 1'b1) calStarts++;
  end

  // Calibration engine: answers after calLat cycles unless told to stay mute.
  initial begin
    forever begin
      do @(posedge clk); while (calStart !== 1'b1);
      if (calMode != 2) begin
        repeat (calLat) @(posedge clk);
        phyCalDone <= 1'b1;
        phyCalPass <= (calMode == 0);
        @(posedge clk);
        phyCalDone <= 1'b0;
        phyCalPass <= (calMode != 0);
      end
    end
  end
endmodule

// >>> sim/mirs_reset_seq_tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Self-checking bench for the reset request sequencer.
// ----------------------------------------------------------------
module mirs_reset_seq_tb;
  localparam int CAL_TO = 50;
  logic                clk;
  logic                rst;
  logic                ce;
  mirs_pkg::mirs_bus_s bus;
  logic [31:0]         rdata;
  logic                resetReqPin, resetDone, usrResetN;
  logic                pllLockPin, pllLocked;
  logic [3:0]          xclk;
  logic                calStart, phyCalDone, phyCalPass;
  logic                calSuccess, calFail, irq;
  logic                rdWas = 1'b0;
  logic [31:0]         rdExpQ [$];
  logic [3:0]          mask;
  logic [3:0]          xclkM;
  logic [3:0]          xclkS;
  int                  numErrors = 0;
  int                  testsRun = 0;

  mirs_reset_seq #(.CAL_TIMEOUT(CAL_TO)) i_mirs_reset_seq (
    .clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
    .resetReqPin(resetReqPin), .resetDone(resetDone), .usrResetN(usrResetN),
    .pllLockPin(pllLockPin), .pllLocked(pllLocked), .xclk(xclk),
    .calStart(calStart), .phyCalDone(phyCalDone), .phyCalPass(phyCalPass),
    .calSuccess(calSuccess), .calFail(calFail), .irq(irq)
  );

  mirs_user_model i_mirs_user_model (
    .clk(clk), .resetDone(resetDone), .calStart(calStart),
    .resetReqPin(resetReqPin), .phyCalDone(phyCalDone), .phyCalPass(phyCalPass)
  );

  // Core clock, 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    checkWord({31'h0, got}, {31'h0, exp});
  endtask

  // One bus cycle; strobes drop at the next edge, so calls never collide.
  task automatic busOp(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    busOp(1'b1, a, d);
  endtask

  task automatic regRd(input logic [7:0] a, input logic [31:0] e);
    rdExpQ.push_back(e);
    busOp(1'b0, a, 32'h0);
  endtask

  // Read data counts only in the cycle after the strobe; it is zero elsewhere.
  always @(posedge clk) rdWas <= bus.rd;
  always @(negedge clk) begin
    if (rdWas && rdExpQ.size() > 0) begin
      checkWord(rdata, rdExpQ.pop_front());
    end else if (rdWas) begin
      numErrors++;
      $display("wrong value at %0t: unexpected read data", $time);
    end else begin
      checkWord(rdata, 32'h0);
    end
  end

  task automatic waitDone;
    int n;
    n = 0;
    while (resetDone !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    checkBit(resetDone, 1'b1);
    checkBit(usrResetN, 1'b0);
    repeat (2) @(negedge clk);
    checkBit(usrResetN, 1'b1);
  endtask

  // Extra clocks are unrelated to the core clock, so they pass two flops before use.
  always @(posedge clk) begin
    xclkM <= xclk;
    xclkS <= xclkM;
  end

  task automatic waitLvl(input int i, input logic v, output int n);
    n = 0;
    while (xclkS[i] !== v && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic giveVerdict;
    $display("Comparisons: %0d, mismatches: %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    int n0;
    void'($urandom(75));
    rst = 1'b1;
    ce = 1'b1;
    bus = '0;
    pllLockPin = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    checkBit(resetDone, 1'b0);
    checkBit(pllLocked, 1'b0);
    checkBit(usrResetN, 1'b0);
    checkWord({28'h0, xclk}, 32'h0);
    regWr(8'h10, 32'hFFFFFFFF);
    for (int a = 0; a <= 16; a += 4) regRd(8'(a), 32'h0);
    // Lock starts the first sequence without any request.
    @(posedge clk);
    pllLockPin <= 1'b1;
    waitDone();
    checkBit(pllLocked, 1'b1);
    checkBit(calSuccess, 1'b1);
    checkBit(irq, 1'b0);
    regRd(mirs_pkg::REG_STATUS, 32'h37);
    regRd(mirs_pkg::REG_IRQ_STAT, 32'h1);
    mask = 4'($urandom) | 4'h1;
    regWr(mirs_pkg::REG_IRQ_MASK, {28'h0, mask});
    regRd(mirs_pkg::REG_IRQ_MASK, {28'h0, mask});
    @(negedge clk);
    checkBit(irq, 1'b1);
    regWr(mirs_pkg::REG_IRQ_STAT, 32'h1);
    repeat (2) @(negedge clk);
    checkBit(irq, 1'b0);
    regRd(mirs_pkg::REG_IRQ_STAT, 32'h0);
    // Pin requests with pass, fail and a mute engine; a soft request in reset is dropped.
    for (int m = 0; m < 3; m++) begin
      i_mirs_user_model.calMode = m;
      i_mirs_user_model.calLat = 1 + $urandom % 20;
      n0 = i_mirs_user_model.calStarts;
      i_mirs_user_model.pulseReq(2 + $urandom % 3);
      repeat (2) @(negedge clk);
      checkBit(resetDone, 1'b0);
      checkBit(usrResetN, 1'b0);
      checkBit(calSuccess | calFail, 1'b0);
      regWr(mirs_pkg::REG_CTRL, 32'h1);
      waitDone();
      checkWord(32'(i_mirs_user_model.calStarts - n0), 32'h1);
      checkBit(calSuccess, m == 0);
      checkBit(calFail, m != 0);
      regRd(mirs_pkg::REG_STATUS, m == 0 ? 32'h37 : 32'h3B);
      regRd(mirs_pkg::REG_IRQ_STAT, m == 0 ? 32'h9 : 32'hB);
      regWr(mirs_pkg::REG_IRQ_STAT, 32'hF);
    end
    i_mirs_user_model.calMode = 0;
    regWr(mirs_pkg::REG_CTRL, 32'h1);
    @(negedge clk);
    checkBit(resetDone, 1'b0);
    // A low clock enable must freeze the sequence far past its normal length.
    @(posedge clk);
    ce <= 1'b0;
    repeat (60) @(negedge clk);
    checkBit(resetDone, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    waitDone();
    checkBit(calSuccess, 1'b1);
    regWr(mirs_pkg::REG_IRQ_STAT, 32'hF);
    // Lock loss drops everything and the sequence restarts on relock.
    @(posedge clk);
    pllLockPin <= 1'b0;
    repeat (5) @(negedge clk);
    checkBit(pllLocked, 1'b0);
    checkBit(resetDone, 1'b0);
    checkBit(irq, mask[2]);
    regRd(mirs_pkg::REG_IRQ_STAT, 32'h4);
    @(posedge clk);
    pllLockPin <= 1'b1;
    waitDone();
    checkBit(pllLocked, 1'b1);
    // Extra clocks: high phase length per output, then all held low.
    regWr(mirs_pkg::REG_CTRL, 32'hF0);
    for (int i = 0; i < 4; i++) begin
      waitLvl(i, 1'b0, n0);
      waitLvl(i, 1'b1, n0);
      waitLvl(i, 1'b0, n0);
      checkWord(32'(n0), 32'(mirs_pkg::XCLK_HALF[i]));
    end
    regWr(mirs_pkg::REG_CTRL, 32'h0);
    repeat (4) @(negedge clk);
    checkWord({28'h0, xclk}, 32'h0);
    repeat (4) @(negedge clk);
    checkWord(32'(rdExpQ.size()), 32'h0);
    giveVerdict();
  end

  // Watchdog, far beyond the few hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    $display("wrong value at %0t: watchdog expired", $time);
    giveVerdict();
  end
endmodule
